// [core/ccmc_pkg.sv]
package ccmc_pkg;
  // ==========================================================
  // Control word field positions (word at offset 0)
  // ==========================================================
  localparam int unsigned CTRL_WORD_OFFSET = 0;
  localparam int unsigned CAL_BIT_POS = 15;
  localparam int unsigned PHASE_BIT_POS = 14;
  localparam int unsigned INTERLEAVE_BIT_POS = 7;
  localparam logic [15:0] CTRL_WORD_RESET = 16'h0000;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SHORT_DELAY_NS = 20480;
  localparam int unsigned LONG_DELAY_NS = 327680;
  localparam int unsigned CAL_RUN_NS = 81920;
  localparam int unsigned SHORT_DELAY_CYC = SHORT_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned LONG_DELAY_CYC = LONG_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned CAL_RUN_CYC = CAL_RUN_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CCMC_WAIT_POR,
    CCMC_IDLE,
    CCMC_RUN
  } ccmc_state_t;
endpackage

// [core/ccmc_req_if.sv]
`timescale 1ns/1ps
// Request path between top and its edge qualifier
interface ccmc_req_if;
  logic raw_req;   // Combined request level
  logic rise;      // One-cycle qualified rise
  logic armed;     // Low level has been seen
  modport src (output raw_req, input rise, input armed);
  modport det (input raw_req, output rise, output armed);
endinterface

// [core/ccmc_req_edge.sv]
`timescale 1ns/1ps
module ccmc_req_edge
  import ccmc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Request path
  ccmc_req_if.det req
);
  // ==========================================================
  // Two-stage sync, then level register for edge
  // ==========================================================
  logic s1_q, s1_d, s2_q, s2_d, lvl_q, lvl_d, arm_q, arm_d;
  logic [1:0] fill_q, fill_d; // Second stage holds a real pin sample once fill_q[1] is set
  // Next values; first stage only feeds second
  always_comb begin
    s1_d = req.raw_req;
    s2_d = s1_q;
    lvl_d = s2_q;
    // Shift in ones until both sync stages carry the pin, not their reset zeros
    fill_d = {fill_q[0], 1'h1};
    // Arm only after a real low was seen; the reset zeros would arm a pin held high
    arm_d = arm_q | (~s2_q & fill_q[1]);
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      lvl_q <= 1'b1;
      arm_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      lvl_q <= lvl_d;
      arm_q <= arm_d;
      fill_q <= fill_d;
    end
  end
  // Rise only counts once a low was seen after reset
  assign req.rise = s2_q & ~lvl_q & arm_q;
  assign req.armed = arm_q;
endmodule

// [core/ccmc_top.sv]
`timescale 1ns/1ps
module ccmc_top
  import ccmc_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_DELAY_CYC,
  parameter int unsigned LONG_CYC = LONG_DELAY_CYC,
  parameter int unsigned RUN_CYC = CAL_RUN_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control pins
  input wire logic cal_request_i,
  input wire logic startup_tune_delay_select_i,
  input wire logic output_strobe_phase_select_i,
  input wire logic interleave_select_i,
  input wire logic nondemux_select_i,
  input wire logic extended_control_enable_n_i,
  // Serial-side control word
  input wire logic [15:0] ctrl_wdata_i,
  input wire logic ctrl_we_i,
  // Status and mode outputs
  output logic selftune_active_o,
  output logic extended_control_mode_o,
  output logic nondemux_mode_o,
  output logic strobe_phase_90_o,
  output logic interleave_mode_o,
  output logic q_channel_input_used_o,
  output logic [15:0] ctrl_word_o
);
  // ==========================================================
  // Control word, cleared while pin control is selected
  // ==========================================================
  logic [15:0] word_q, word_d;
  logic extended_control_mode;
  assign extended_control_mode = ~extended_control_enable_n_i;
  // Write only in extended mode; defaults otherwise
  always_comb begin
    word_d = word_q;
    if (!extended_control_mode) begin
      word_d = CTRL_WORD_RESET;
    end else if (ctrl_we_i) begin
      word_d = ctrl_wdata_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_q <= CTRL_WORD_RESET;
    end else begin
      word_q <= word_d;
    end
  end
  // ==========================================================
  // Request combining and edge qualifier
  // ==========================================================
  ccmc_req_if req ();
  // Bit only contributes in extended mode
  assign req.raw_req = cal_request_i | (extended_control_mode & word_q[CAL_BIT_POS]);
  ccmc_req_edge u_edge (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .req(req)
  );
  // ==========================================================
  // Calibration sequencer
  // ==========================================================
  ccmc_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic run_d;
  logic por_inhibit_q, por_inhibit_d;
  logic inh_seen_q, inh_seen_d;
  // Delay pin only, in every mode
  function automatic logic [31:0] startup_wait(input logic long_sel);
    startup_wait = long_sel ? 32'(LONG_CYC) : 32'(SHORT_CYC);
  endfunction
  // Next state; requests while running are dropped
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    por_inhibit_d = por_inhibit_q;
    inh_seen_d = 1'b1;
    // Catch request level at first cycle after release
    if (!inh_seen_q) begin
      por_inhibit_d = cal_request_i;
    end
    case (st_q)
      CCMC_WAIT_POR: begin
        if (req.rise) begin
          st_d = CCMC_RUN;
          cnt_d = 32'h00000000;
        end else if (!inh_seen_q || por_inhibit_q) begin
          cnt_d = 32'h00000000;  // Hold while inhibited
        end else if (cnt_q + 32'h00000001 >= startup_wait(startup_tune_delay_select_i)) begin
          st_d = CCMC_RUN;
          cnt_d = 32'h00000000;
        end else begin
          cnt_d = cnt_q + 32'h00000001;
        end
      end
      CCMC_IDLE: begin
        if (req.rise) begin
          st_d = CCMC_RUN;
          cnt_d = 32'h00000000;
        end
      end
      CCMC_RUN: begin
        // Rises here are ignored, not queued
        if (cnt_q + 32'h00000001 >= 32'(RUN_CYC)) begin
          st_d = CCMC_IDLE;
          cnt_d = 32'h00000000;
        end else begin
          cnt_d = cnt_q + 32'h00000001;
        end
      end
      default: begin
        st_d = CCMC_IDLE;
      end
    endcase
    run_d = (st_d == CCMC_RUN);
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= CCMC_WAIT_POR;
      cnt_q <= 32'h00000000;
      por_inhibit_q <= 1'b0;
      inh_seen_q <= 1'b0;
      selftune_active_o <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      por_inhibit_q <= por_inhibit_d;
      inh_seen_q <= inh_seen_d;
      selftune_active_o <= run_d;
    end
  end
  // ==========================================================
  // Mode selection outputs
  // ==========================================================
  logic ndm_d, ph_d, il_d, qin_d;
  // Phase and interleave from pins in pin mode, word bits in extended mode; nondemux from its pin in both
  always_comb begin
    ndm_d = nondemux_select_i;
    if (extended_control_mode) begin
      ph_d = word_q[PHASE_BIT_POS];
      il_d = word_q[INTERLEAVE_BIT_POS];
    end else begin
      ph_d = output_strobe_phase_select_i;
      il_d = interleave_select_i;
    end
    // Phase meaningless in 1:1 mode, forced to 0 degrees
    if (ndm_d) begin
      ph_d = 1'b0;
    end
    qin_d = ~il_d;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      extended_control_mode_o <= 1'b0;
      nondemux_mode_o <= 1'b0;
      strobe_phase_90_o <= 1'b0;
      interleave_mode_o <= 1'b0;
      q_channel_input_used_o <= 1'b1;
      ctrl_word_o <= CTRL_WORD_RESET;
    end else begin
      extended_control_mode_o <= extended_control_mode;
      nondemux_mode_o <= ndm_d;
      strobe_phase_90_o <= ph_d;
      interleave_mode_o <= il_d;
      q_channel_input_used_o <= qin_d;
      ctrl_word_o <= word_d;
    end
  end
endmodule

// [testbench/ccmc_chk.sv]
`timescale 1ns/1ps
// ====
// Checker on the top ports
module ccmc_chk #(parameter int unsigned RUN_CYC = 20) (
  // Clock, reset and pins
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic output_strobe_phase_select_i,
  input wire logic interleave_select_i,
  input wire logic nondemux_select_i,
  input wire logic extended_control_enable_n_i,
  // Outputs
  input wire logic selftune_active_o,
  input wire logic extended_control_mode_o,
  input wire logic nondemux_mode_o,
  input wire logic strobe_phase_90_o,
  input wire logic interleave_mode_o,
  input wire logic q_channel_input_used_o,
  input wire logic [15:0] ctrl_word_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  int unsigned run_q; // High cycles of the active flag so far
  // Counter avoids a long repetition
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 0;
    end else begin
      run_q <= selftune_active_o ? run_q + 1 : 0;
    end
  end
  run_len_a: assert property ($fell(selftune_active_o) |-> run_q == RUN_CYC)
    else $error("run length");
  ecm_mode_a: assert property (1'b1 |=> extended_control_mode_o ==
    !$past(extended_control_enable_n_i)) else $error("mode flag");
  ndm_mode_a: assert property (1'b1 |=> nondemux_mode_o == $past(nondemux_select_i))
    else $error("nondemux");
  pin_phase_a: assert property (extended_control_enable_n_i && !nondemux_select_i
    |=> strobe_phase_90_o == $past(output_strobe_phase_select_i)) else $error("phase");
  phase_ndm_a: assert property (nondemux_mode_o |-> !strobe_phase_90_o)
    else $error("phase in 1:1");
  pin_il_a: assert property (extended_control_enable_n_i
    |=> interleave_mode_o == $past(interleave_select_i)) else $error("interleave");
  q_used_a: assert property (q_channel_input_used_o != interleave_mode_o)
    else $error("q input");
  word_clr_a: assert property (extended_control_enable_n_i |=> ctrl_word_o == 16'h0000)
    else $error("word kept");
  cover property ($rose(selftune_active_o));
  cover property (extended_control_mode_o && strobe_phase_90_o);
  cover property (interleave_mode_o && !extended_control_mode_o);
endmodule

// [testbench/ccmc_host_model.sv]
`timescale 1ns/1ps
// ====
// Host side driving the request pin
module ccmc_host_model (
  // Clock
  input wire logic core_clk_i,
  // Request pin
  output logic cal_request_o
);
  initial cal_request_o = 1'b0;
  // Level change just after an edge
  task automatic drive(input logic v);
    cal_request_o <= v;
  endtask
  // Low for n cycles, then high and held
  task automatic cal_pulse(input int n);
    cal_request_o <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    cal_request_o <= 1'b1;
  endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
// ====
// Bench: short counts keep the run brief
module testbench;
  localparam int unsigned SC = 8;
  localparam int unsigned LC = 16;
  localparam int unsigned RC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req, dly = 1'b0, ph = 1'b0, il = 1'b0, nd = 1'b0, en_n = 1'b1, we = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic act, extended_control_mode, nd_o, ph_o, il_o, q_o;
  logic [15:0] wo;
  int errors = 0;
  int check_count = 0;
  int ts, tl, n;
  always #10 clk = ~clk;
  ccmc_host_model host_i (.core_clk_i(clk), .cal_request_o(req));
  ccmc_top #(.SHORT_CYC(SC), .LONG_CYC(LC), .RUN_CYC(RC)) ccmc_top_i (
    .core_clk_i(clk), .rst_i(rst), .cal_request_i(req), .startup_tune_delay_select_i(dly),
    .output_strobe_phase_select_i(ph), .interleave_select_i(il), .nondemux_select_i(nd),
    .extended_control_enable_n_i(en_n), .ctrl_wdata_i(wd), .ctrl_we_i(we),
    .selftune_active_o(act), .extended_control_mode_o(extended_control_mode), .nondemux_mode_o(nd_o),
    .strobe_phase_90_o(ph_o), .interleave_mode_o(il_o), .q_channel_input_used_o(q_o),
    .ctrl_word_o(wo));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Bounded count of edges while the active flag equals v
  task automatic wait_act(input logic v, output int k);
    k = 0;
    while (act === v && k < 2000) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic boot(input logic d, input logic r);
    rst <= 1'b1;
    dly <= d;
    host_i.drive(r);
    cyc(4);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] v);
    we <= 1'b1;
    wd <= v;
    cyc(1);
    we <= 1'b0;
    cyc(2);
  endtask
  initial begin
    boot(1'b0, 1'b0);
    wait_act(1'b0, ts);
    wait_act(1'b1, n);
    check("run length", 16'(n), 16'(RC));
    boot(1'b1, 1'b0);
    wait_act(1'b0, tl);
    check("delay gap", 16'(tl - ts), 16'(LC - SC));
    wait_act(1'b1, n);
    boot(1'b0, 1'b1);
    n = 0;
    // Any active cycle in the start-up span counts, not only the last one
    repeat (LC + 10) begin
      cyc(1);
      if (act !== 1'b0) n = 1;
    end
    check("inhibited", 16'(n), 16'h0000);
    host_i.cal_pulse(4);
    wait_act(1'b0, n);
    check("start lag", {15'h0, n >= 3 && n <= 6}, 16'h0001);
    cyc(2);
    host_i.cal_pulse(4);
    wait_act(1'b1, n);
    cyc(12);
    check("one run", {15'h0, act}, 16'h0000);
    // Every phase, interleave and nondemux pin combination in pin mode
    for (int k = 0; k < 8; k++) begin
      ph <= k[0];
      il <= k[1];
      nd <= k[2];
      cyc(2);
      check("phase", {15'h0, ph_o}, {15'h0, ph & ~nd});
      check("interleave", {14'h0, il_o, q_o}, {14'h0, il, ~il});
      check("nondemux", {14'h0, nd_o, extended_control_mode}, {14'h0, nd, 1'b0});
    end
    en_n <= 1'b0;
    nd <= 1'b0;
    cyc(2);
    check("ext reset", {13'h0, extended_control_mode, ph_o, il_o}, 16'h0004);
    wr(16'h4080);
    check("ext bits", {14'h0, ph_o, il_o}, 16'h0003);
    check("word", wo, 16'h4080);
    host_i.drive(1'b0);
    wr(16'h0000);
    cyc(4);
    wr(16'h8000);
    wait_act(1'b0, n);
    check("bit start", {15'h0, act}, 16'h0001);
    en_n <= 1'b1;
    cyc(2);
    check("word cleared", {wo[15:1], extended_control_mode}, 16'h0000);
    test_done();
  end
  initial begin
    #200us;
    errors++;
    test_done();
  end
endmodule
bind ccmc_top ccmc_chk #(.RUN_CYC(RUN_CYC)) ccmc_chk_i (.core_clk_i, .rst_i,
  .output_strobe_phase_select_i, .interleave_select_i, .nondemux_select_i,
  .extended_control_enable_n_i, .selftune_active_o, .extended_control_mode_o,
  .nondemux_mode_o, .strobe_phase_90_o, .interleave_mode_o, .q_channel_input_used_o,
  .ctrl_word_o);
